/* design/adci_ctrl.sv */
/*
  Host controller for a 64K x 4 asynchronous memory with multiplexed row and
  column address: power-up pause and init cycles, column-before-row refresh,
  single early-write and read accesses.
  Assumes the memory pins are wired directly; the data bus is resolved
  outside from data_io_oe_o. User requests come from logic on sys_clk_i.
*/
`timescale 1ns/1ns
module adci_ctrl #(
  parameter int POWERUP_PAUSE_CYC = adci_pkg::PAUSE_CYC
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     srst_i,
  input  wire logic                     ce_i,
  input  wire logic                     req_valid_i,
  input  wire adci_pkg::adci_req_type   req_i,
  output logic                          req_ready_o,
  output logic                          rdata_valid_o,
  output logic [3:0]                    rdata_o,
  output logic                          init_done_o,
  output adci_pkg::adci_strobe_type     strobe_o,
  output logic [7:0]                    mux_addr_o,
  input  wire logic [3:0]               data_io_i,
  output logic [3:0]                    data_io_o,
  output logic                          data_io_oe_o
);
  import adci_pkg::*;

  localparam logic [15:0] PAUSE_LAST = 16'(POWERUP_PAUSE_CYC - 1);

  adci_state_type state_r;
  adci_req_type   cur_r;
  logic [15:0]    cnt_r;
  logic [3:0]     init_left_r;
  logic [3:0]     dq_s1_r;
  logic [3:0]     dq_s2_r;
  logic           ref_pending;
  logic           ref_ack;
  logic           accept;
  logic           cnt_done;

  // length of the state being left, compared against the running counter
  function automatic logic state_done(input adci_state_type st,
                                      input logic [15:0] cnt,
                                      input logic [15:0] pause_last);
    unique case (st)
      ST_PAUSE: state_done = (cnt == pause_last);
      ST_ROW:   state_done = (cnt == ROW_CYC - 16'h0001);
      ST_COL:   state_done = (cnt == COL_CYC - 16'h0001);
      ST_PRE:   state_done = (cnt == PRE_CYC - 16'h0001);
      ST_RCAS:  state_done = (cnt == CSR_LEN - 16'h0001);
      ST_RRAS:  state_done = (cnt == RAS_LEN - 16'h0001);
      default:  state_done = 1'b1;
    endcase
  endfunction

  assign cnt_done = state_done(state_r, cnt_r, PAUSE_LAST);
  // a take always matches the ready shown before the edge, even when a refresh
  // slot opens at that edge; the refresh then waits for one access only
  assign accept   = (state_r == ST_IDLE) && req_ready_o && req_valid_i;
  assign ref_ack  = (state_r == ST_IDLE) && ref_pending && init_done_o && !accept;

  adci_refresh_timer u_refresh (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .ack_i     (ref_ack),
    .pending_o (ref_pending)
  );

  // two-flop synchroniser: the memory answers with no relation to our clock
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dq_s1_r <= DATA_RST;
      dq_s2_r <= DATA_RST;
    end else if (ce_i) begin
      dq_s1_r <= data_io_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  // per-state cycle counter, cleared on every state change
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_r <= 16'h0000;
    end else if (ce_i) begin
      if (cnt_done || state_r == ST_IDLE) begin
        cnt_r <= 16'h0000;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // sequencer
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_r <= ST_PAUSE;
    end else if (ce_i) begin
      unique case (state_r)
        ST_PAUSE: if (cnt_done) state_r <= ST_IDLE;
        ST_IDLE: begin
          if (accept) begin
            state_r <= ST_ROW;
          end else if (!init_done_o || ref_pending) begin
            state_r <= ST_RCAS;
          end
        end
        ST_ROW:  if (cnt_done) state_r <= ST_COL;
        ST_COL:  if (cnt_done) state_r <= ST_PRE;
        ST_RCAS: if (cnt_done) state_r <= ST_RRAS;
        ST_RRAS: if (cnt_done) state_r <= ST_PRE;
        ST_PRE:  if (cnt_done) state_r <= ST_IDLE;
      endcase
    end
  end

  // eight refresh cycles after the pause count as the init row-strobe cycles
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      init_left_r <= INIT_CNT;
      init_done_o <= 1'b0;
    end else if (ce_i) begin
      if (state_r == ST_RRAS && cnt_done && !init_done_o) begin
        init_left_r <= init_left_r - 4'h1;
        init_done_o <= (init_left_r == 4'h1);
      end
    end
  end

  // capture the request; held stable for the whole access
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cur_r <= '0;
    end else if (ce_i && accept) begin
      cur_r <= req_i;
    end
  end

  // ready is registered and only offered in idle with nothing more urgent
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      req_ready_o <= 1'b0;
    end else if (ce_i) begin
      req_ready_o <= (state_r == ST_PRE && cnt_done && init_done_o && !ref_pending)
                  || (state_r == ST_IDLE && init_done_o && !ref_pending && !req_valid_i);
    end
  end

  // strobe pins; each level is set on state entry so pins come from flops
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      strobe_o <= STROBE_RST;
    end else if (ce_i) begin
      if (accept) begin
        strobe_o.ras_n <= 1'b0;
        // write select falls with the row strobe, well ahead of the column strobe
        strobe_o.we_n  <= !req_i.write;
      end else if (state_r == ST_IDLE && (ref_pending || !init_done_o)) begin
        strobe_o.cas_n <= 1'b0;
      end else if (state_r == ST_ROW && cnt_done) begin
        // row to column spacing sits at its minimum, inside the access reference
        strobe_o.cas_n <= 1'b0;
        strobe_o.oe_n  <= cur_r.write;
      end else if (state_r == ST_RCAS && cnt_done) begin
        strobe_o.ras_n <= 1'b0;
      end else if ((state_r == ST_COL || state_r == ST_RRAS) && cnt_done) begin
        // strobes all rise together; minimum row width was counted before this
        strobe_o <= STROBE_RST;
      end
    end
  end

  // address mux: row with the row strobe, column one cycle before column strobe
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mux_addr_o <= ADDR_RST;
    end else if (ce_i) begin
      if (accept) begin
        mux_addr_o <= req_i.addr[15:8];
      end else if (state_r == ST_ROW && cnt_r == 16'h0000) begin
        mux_addr_o <= cur_r.addr[7:0];
      end
    end
  end

  // data drive: only for writes, dropped as the access ends, so a read never
  // finds our driver on when column strobe or output enable fall
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      data_io_o    <= DATA_RST;
      data_io_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (accept) begin
        data_io_o    <= req_i.wdata;
        data_io_oe_o <= req_i.write;
      end else if (state_r == ST_COL && cnt_done) begin
        data_io_oe_o <= 1'b0;
      end
    end
  end

  // read capture after column access time plus the synchroniser delay
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_o       <= DATA_RST;
      rdata_valid_o <= 1'b0;
    end else if (ce_i) begin
      rdata_valid_o <= 1'b0;
      if (state_r == ST_COL && !cur_r.write && cnt_r == RD_SMP_CYC) begin
        rdata_o       <= dq_s2_r;
        rdata_valid_o <= 1'b1;
      end
    end
  end

endmodule

/* design/adci_pkg.sv */
/*
  Shared constants and carrier types for the host-side controller of a
  64K x 4 multiplexed-address asynchronous memory.
  Assumes one 50 MHz clock and the memory's strobes driven from flip-flops.
*/
// Functional notes
// - after power-up wait the initial pause, then run eight row-strobe cycles
// - row-to-column delay maximum is a reference only; longer delays stay legal
// - write select must be early or late enough, otherwise output indeterminate
// - release input data before column strobe or output enable falls
// - refresh all 256 rows within every 4 ms interval
// - reads keep write select high for the whole cycle, output enable low
package adci_pkg;

  localparam int CLK_PERIOD_NS = 20;

  // device times in ns for the slower speed grade
  localparam int T_RCD_MIN_NS  = 25;
  localparam int T_CAC_NS      = 75;
  localparam int T_RAS_MIN_NS  = 150;
  localparam int T_RAS_MAX_NS  = 10000;
  localparam int T_RP_NS       = 100;
  localparam int T_CSR_NS      = 30;
  localparam int T_REF_NS      = 4000000;
  localparam int REF_ROWS      = 256;
  localparam int T_PAUSE_US    = 100;
  localparam int INIT_CYCLES   = 8;
  localparam int SYNC_STAGES   = 2;

  // least times round up, longest times round down
  localparam int RCD_CYC     = (T_RCD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAC_CYC     = (T_CAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_CYC     = (T_RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_MAX_CYC = T_RAS_MAX_NS / CLK_PERIOD_NS;
  localparam int RP_CYC      = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSR_CYC     = (T_CSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_INT_CYC = (T_REF_NS / REF_ROWS) / CLK_PERIOD_NS;
  localparam int PAUSE_CYC   = (T_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // column phase of an access: data sampled after access time plus synchroniser
  localparam logic [15:0] RD_SMP_CYC = 16'(CAC_CYC + SYNC_STAGES);
  localparam logic [15:0] COL_CYC    = 16'(CAC_CYC + SYNC_STAGES + 1);
  localparam logic [15:0] ROW_CYC    = 16'(RCD_CYC);
  localparam logic [15:0] PRE_CYC    = 16'(RP_CYC);
  localparam logic [15:0] CSR_LEN    = 16'(CSR_CYC);
  localparam logic [15:0] RAS_LEN    = 16'(RAS_CYC);
  localparam logic [3:0]  INIT_CNT   = 4'(INIT_CYCLES);

  localparam logic        STROBE_IDLE = 1'b1;
  localparam logic [7:0]  ADDR_RST    = 8'h00;
  localparam logic [3:0]  DATA_RST    = 4'h0;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;   // [15:8] row, [7:0] column
    logic [3:0]  wdata;
  } adci_req_type;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe_n;
  } adci_strobe_type;

  localparam adci_strobe_type STROBE_RST = '{STROBE_IDLE, STROBE_IDLE,
                                             STROBE_IDLE, STROBE_IDLE};

  typedef enum logic [6:0] {
    ST_PAUSE = 7'b0000001,
    ST_IDLE  = 7'b0000010,
    ST_ROW   = 7'b0000100,
    ST_COL   = 7'b0001000,
    ST_PRE   = 7'b0010000,
    ST_RCAS  = 7'b0100000,
    ST_RRAS  = 7'b1000000
  } adci_state_type;

endpackage

/* design/adci_refresh_timer.sv */
/*
  Refresh interval timer: raises a pending flag once per row interval.
  Assumes the acknowledge is a one-cycle pulse from the same clock domain.
*/
`timescale 1ns/1ns
module adci_refresh_timer (
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  input  wire logic ack_i,
  output logic      pending_o
);
  import adci_pkg::*;

  localparam logic [9:0] INT_LAST = 10'(REF_INT_CYC - 1);

  logic [9:0] tick_r;
  logic       tick_hit;

  assign tick_hit = (tick_r == INT_LAST);

  // free-running interval counter, one wrap per refresh slot
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tick_r <= 10'h000;
    end else if (ce_i) begin
      tick_r <= tick_hit ? 10'h000 : tick_r + 10'h001;
    end
  end

  // a new slot in the acknowledge cycle stays pending so no row is skipped
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pending_o <= 1'b0;
    end else if (ce_i) begin
      if (tick_hit) begin
        pending_o <= 1'b1;
      end else if (ack_i) begin
        pending_o <= 1'b0;
      end
    end
  end

endmodule

/* testbench/adci_ctrl_props.sv */
/* assertions on the strobe controller ports
   assumes one clock domain and a bind onto adci_ctrl */
`timescale 1ns/1ns
module adci_ctrl_props #(
  parameter int POWERUP_PAUSE_CYC = 20
) (
  input wire logic                      sys_clk_i,
  input wire logic                      srst_i,
  input wire logic                      rdata_valid_o,
  input wire logic                      init_done_o,
  input wire adci_pkg::adci_strobe_type strobe_o,
  input wire logic                      data_io_oe_o
);
  import adci_pkg::*;
  localparam int GAP_MAX = 820;  // one refresh slot plus one deferring access
  localparam int RAS_MAX = 500;
  logic [15:0] cyc_r;
  logic [15:0] low_r;
  logic [15:0] gap_r;
  logic [3:0]  rcnt_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // saturating counters, so a long run cannot wrap them into a false pass
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cyc_r  <= 16'h0000;
      rcnt_r <= 4'h0;
    end else begin
      if (cyc_r != 16'hFFFF) cyc_r <= cyc_r + 16'h0001;
      if ($fell(strobe_o.ras_n) && rcnt_r != 4'hF) rcnt_r <= rcnt_r + 4'h1;
    end
  end
  // row-low time and cycles since the last column-first refresh
  always_ff @(posedge sys_clk_i) begin
    low_r <= strobe_o.ras_n ? 16'h0000 : low_r + 16'h0001;
    if (!init_done_o || ($fell(strobe_o.ras_n) && !strobe_o.cas_n)) gap_r <= 16'h0000;
    else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
  end
  sequence s_read_start; $fell(strobe_o.ras_n) && strobe_o.cas_n && strobe_o.we_n; endsequence
  sequence s_write_start; $fell(strobe_o.ras_n) && strobe_o.cas_n && !strobe_o.we_n; endsequence
  sequence s_read_col; $fell(strobe_o.cas_n) && !strobe_o.ras_n && strobe_o.we_n; endsequence
  property p_pause; $fell(strobe_o.ras_n) |-> cyc_r >= POWERUP_PAUSE_CYC; endproperty
  a_pause: assert property (p_pause) else $error("row strobe inside power-up pause");
  property p_init; $rose(init_done_o) |-> rcnt_r >= 4'h8; endproperty
  a_init: assert property (p_init) else $error("ready before eight row cycles");
  property p_ras_max; low_r <= RAS_MAX; endproperty
  a_ras_max: assert property (p_ras_max) else $error("row strobe low too long");
  property p_ref_gap; gap_r <= GAP_MAX; endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("refresh slot missed");
  property p_cbr;
    $fell(strobe_o.cas_n) && strobe_o.ras_n |-> ##[1:3] ($fell(strobe_o.ras_n) && !strobe_o.cas_n);
  endproperty
  a_cbr: assert property (p_cbr) else $error("column-first refresh incomplete");
  property p_rel_oe; !strobe_o.oe_n |-> !data_io_oe_o; endproperty
  a_rel_oe: assert property (p_rel_oe) else $error("data driven with output enable low");
  property p_rd_we; s_read_start |-> strobe_o.we_n [*8]; endproperty
  a_rd_we: assert property (p_rd_we) else $error("write select moved in a read");
  property p_early;
    s_write_start |-> (!strobe_o.we_n && strobe_o.cas_n) [*2] ##1 (!strobe_o.we_n && !strobe_o.cas_n);
  endproperty
  a_early: assert property (p_early) else $error("write select not ahead of column");
  property p_access; s_read_col |-> ##7 rdata_valid_o; endproperty
  a_access: assert property (p_access) else $error("read data late");
endmodule
bind adci_ctrl adci_ctrl_props #(.POWERUP_PAUSE_CYC(POWERUP_PAUSE_CYC)) u_props (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .rdata_valid_o(rdata_valid_o),
  .init_done_o(init_done_o), .strobe_o(strobe_o), .data_io_oe_o(data_io_oe_o));

/* testbench/adci_ctrl_tb_top.sv */
/* self-checking bench for adci_ctrl with a behavioural memory
   assumes a 50 MHz clock and a shortened power-up pause */
`timescale 1ns/1ns
module adci_ctrl_tb_top;
  import adci_pkg::*;
  localparam int PAUSE = 20;
  logic            sys_clk_i = 1'b0;
  logic            srst_i = 1'b1;
  logic            ce_i = 1'b1;
  logic            req_valid_i = 1'b0;
  adci_req_type    req_i = '0;
  logic            req_ready_o, rdata_valid_o, init_done_o, data_io_oe_o, q_en;
  logic [3:0]      rdata_o, data_io_o, q;
  logic [3:0]      last = 4'h0;
  logic [7:0]      mux_addr_o, ref_cnt;
  adci_strobe_type strobe_o;
  logic [15:0]     rnd = 16'h3278;
  logic [15:0]     adr[$];
  logic [3:0]      exp_q[$];
  logic [3:0]      img [0:65535];
  int              err_total = 0;
  int              n_tests = 0;
  wire  [3:0]      bus = data_io_oe_o ? data_io_o : (q_en ? q : ~last);
  always #10 sys_clk_i = ~sys_clk_i;
  // a released bus flips, so a stale level can never pass for data
  always @(posedge sys_clk_i) last <= bus;
  adci_ctrl #(.POWERUP_PAUSE_CYC(PAUSE)) DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .ce_i(ce_i), .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o), .init_done_o(init_done_o),
    .strobe_o(strobe_o), .mux_addr_o(mux_addr_o), .data_io_i(bus), .data_io_o(data_io_o),
    .data_io_oe_o(data_io_oe_o));
  adci_mem_model u_mem (.strobe_i(strobe_o), .mux_addr_i(mux_addr_o), .data_i(bus),
    .q_o(q), .q_en_o(q_en), .ref_cnt_o(ref_cnt));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // holds the request until ready was seen, then notes the expected word
  task automatic access(input logic wr, input logic [15:0] a, input logic [3:0] d);
    int i;
    i = 0;
    req_i = {wr, a, d};
    req_valid_i = 1'b1;
    do begin
      @(negedge sys_clk_i);
      i++;
    end while (req_ready_o !== 1'b1 && i < 3000);
    if (i >= 3000) begin
      err_total++;
      report_and_stop();
    end
    @(posedge sys_clk_i);
    #2;
    if (wr) img[a] = d;
    else exp_q.push_back(img[a]);
  endtask
  // read results are compared mid-cycle, where the pulse has settled
  always @(negedge sys_clk_i) begin
    if (rdata_valid_o === 1'b1 && exp_q.size() == 0) check("spare read", 16'h0001, 16'h0000);
    else if (rdata_valid_o === 1'b1) check("read data", 16'(rdata_o), 16'(exp_q.pop_front()));
  end
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
  // main sequence: init, corner and random words, stall, refresh, drain
  initial begin
    int i;
    repeat (3) @(posedge sys_clk_i);
    #2 srst_i = 1'b0;
    for (i = 0; i < 3000 && init_done_o !== 1'b1; i++) @(negedge sys_clk_i);
    check("init done", 16'(init_done_o), 16'h0001);
    check("init rows", 16'(ref_cnt), 16'h0008);
    $display("test init done");
    adr = '{16'h0000, 16'hFFFF, 16'h00FF, 16'hFF00};
    repeat (4) begin
      rnd = lfsr(rnd);
      adr.push_back(rnd);
    end
    // requests start just after a rising edge, like every later one
    @(posedge sys_clk_i);
    #2;
    foreach (adr[k]) begin
      rnd = lfsr(rnd);
      access(1'b1, adr[k], rnd[3:0]);
    end
    access(1'b1, adr[0], ~img[adr[0]]);
    foreach (adr[k]) access(1'b0, adr[k], 4'h0);
    $display("test write read done");
    access(1'b0, adr[1], 4'h0);
    ce_i = 1'b0;
    req_valid_i = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    #2 ce_i = 1'b1;
    repeat (1700) @(posedge sys_clk_i);
    #2;
    check("refresh rows", 16'(ref_cnt >= 8'h0A), 16'h0001);
    foreach (adr[k]) access(1'b0, adr[k], 4'h0);
    req_valid_i = 1'b0;
    for (i = 0; i < 100 && exp_q.size() > 0; i++) @(negedge sys_clk_i);
    check("pending reads", 16'(exp_q.size()), 16'h0000);
    $display("test refresh done");
    report_and_stop();
  end
endmodule

/* testbench/adci_mem_model.sv */
/* behavioural 64K x 4 memory on the strobe pins
   assumes strobes from adci_ctrl and times in ns */
`timescale 1ns/1ns
module adci_mem_model (
  input  wire adci_pkg::adci_strobe_type strobe_i,
  input  wire logic [7:0]                mux_addr_i,
  input  wire logic [3:0]                data_i,
  output logic [3:0]                     q_o,
  output logic                           q_en_o,
  output logic [7:0]                     ref_cnt_o
);
  import adci_pkg::*;
  logic [3:0] mem [0:65535];
  logic [7:0] row_r = 8'h00;
  logic [7:0] col_r = 8'h00;
  logic       wr_r = 1'b0;
  logic       vld_r = 1'b0;
  initial ref_cnt_o = 8'h00;
  // row strobe: column already low means refresh of the counter row
  always @(negedge strobe_i.ras_n) begin
    #1;
    if (!strobe_i.cas_n) ref_cnt_o = ref_cnt_o + 8'h01;
    else row_r = mux_addr_i;
  end
  // column strobe: write select low already is an early write, else a read
  always @(negedge strobe_i.cas_n) begin
    col_r = mux_addr_i;
    wr_r = !strobe_i.ras_n && !strobe_i.we_n;
    if (wr_r) mem[{row_r, col_r}] = data_i;
    q_o = mem[{row_r, col_r}];
    #(T_CAC_NS) vld_r = !strobe_i.cas_n;
  end
  // late write select stores while the read word stays on the pins
  always @(negedge strobe_i.we_n) begin
    if (!strobe_i.cas_n && !strobe_i.ras_n) mem[{row_r, col_r}] = data_i;
  end
  always @(posedge strobe_i.cas_n) vld_r = 1'b0;
  // pins driven only with column strobe and output enable low, held across a new row cycle
  assign q_en_o = vld_r && !wr_r && !strobe_i.cas_n && !strobe_i.oe_n;
endmodule
